// ### logic/core_defs.svh
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH

`define IR_MSB 13
`define ACC_RESET 8'h00
`define LIT_ZERO 8'h00

// instruction classes, bits 13:12
`define CLASS_BYTE 2'h0
`define CLASS_BIT 2'h1
`define CLASS_JUMP 2'h2
`define CLASS_LIT 2'h3

// byte-class operation field, bits 11:8
`define BOP_STORE 4'h0
`define BOP_CLEAR 4'h1
`define BOP_SUB 4'h2
`define BOP_DEC 4'h3
`define BOP_OR 4'h4
`define BOP_AND 4'h5
`define BOP_XOR 4'h6
`define BOP_ADD 4'h7
`define BOP_MOVE 4'h8
`define BOP_COMP 4'h9
`define BOP_INC 4'ha
`define BOP_DECSZ 4'hb
`define BOP_RRC 4'hc
`define BOP_RLC 4'hd
`define BOP_SWAP 4'he
`define BOP_INCSZ 4'hf

// control words, bits 7:0 under field 0000
`define CW_RETURN 8'h08
`define CW_INT_RETURN 8'h09
`define CW_WDT_CLEAR 8'h64
`define CW_SLEEP 8'h63
// clear-accumulator word, bits 7:0 under field 0001
`define CW_CLEAR_ACC 8'h03
`define IDLE_LOW_MASK 8'h9f

// bit-class operation, bits 11:10
`define BITOP_CLEAR 2'h0
`define BITOP_SET 2'h1
`define BITOP_SKIP_CLR 2'h2
`define BITOP_SKIP_SET 2'h3

// literal-class operation, bits 11:8
`define LOP_ADD 4'b111?
`define LOP_SUB 4'b110?
`define LOP_AND 4'b1001
`define LOP_OR 4'b1000
`define LOP_XOR 4'b1010
`define LOP_LOAD 4'b00??
`define LOP_RETURN 4'b01??

// register map, byte addresses
`define REG_CTRL 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_INFO 8'h0c

// status bit positions
`define ST_C 0
`define ST_NIBBLE 1
`define ST_Z 2
`define ST_SLEPT 3
`define ST_EXPIRED 4
`define CTRL_RUN 0

`endif

// ### logic/core_pkg.sv
`default_nettype none
package core_pkg;

	// thirty-five operations do not fit five bits
	typedef enum logic [5:0] {
		no_operation, add_acc_to_reg, and_acc_with_reg, clear_reg, clear_acc,
		complement_reg, decrement_reg, decrement_skip_zero, increment_reg,
		increment_skip_zero, or_acc_with_reg, move_reg, store_acc_to_reg,
		rotate_left_carry, rotate_right_carry, sub_acc_from_reg, swap_nibbles,
		xor_acc_with_reg, bit_clear_op, bit_set_op, test_skip_if_clear,
		test_skip_if_set, add_literal_op, and_literal_op, call_op, jump_op,
		or_literal_op, load_literal_op, return_with_literal, return_op,
		interrupt_return_op, sub_from_literal_op, xor_literal_op, watchdog_clear_op,
		sleep_op
	} op_t;

	// four oscillator periods make one instruction cycle
	typedef enum logic [3:0] {
		phase_q1 = 4'b0001,
		phase_q2 = 4'b0010,
		phase_q3 = 4'b0100,
		phase_q4 = 4'b1000
	} phase_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic pc_load;
		logic [10:0] pc_target;
		logic call_push;
		logic return_pop;
		logic interrupt_return;
		logic watchdog_clear;
		logic sleep_req;
		logic prescaler_clear;
	} flow_ctl_t;

	typedef struct packed {
		phase_t phase;
		logic run;
		logic [13:0] ir;
		logic flush;
		logic exec_nop;
		logic [7:0] operand;
		logic [7:0] acc;
		logic carry;
		logic nibble_carry;
		logic zero;
		logic watchdog_expired_flag;
		logic sleep_entered_flag;
		logic [15:0] cycle_count;
		logic instr_fetch;
		logic [6:0] file_addr;
		logic file_wr_en;
		logic [7:0] file_wr_data;
		flow_ctl_t flow;
		wb_rsp_t wb;
	} core_state_t;

endpackage : core_pkg
`default_nettype wire

// ### logic/instr_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "core_defs.svh"

// Notes on behaviour
// RULE_01: every word decodes as byte, bit, or literal/control class.
// RULE_02: seven low bits address file register 0x00 to 0x7F.
// RULE_03: byte ops write accumulator when d is 0, file register when 1.
// RULE_04: three-bit field picks bit cleared, set or tested.
// RULE_05: don't-care bits ignored; no-operation pattern, clear-accumulator sets zero.
// RULE_06: one cycle, two when skip taken or program counter changes.
// RULE_07: one instruction cycle is four clock periods.
// RULE_08: add, subtract set carry, nibble carry, zero; and, or, xor set zero.
// RULE_09: decrement/increment set Z; skip forms skip on zero, no flags.
// RULE_10: rotates go through carry and touch carry only.
// RULE_11: complement, move set Z; swap none; clear sets Z; store acc.
// RULE_12: bit class: clear, set, skip if clear, skip if set.
// RULE_13: true bit test discards next word, runs no-operation instead.
// RULE_14: class 10 calls or jumps to eleven-bit target, two cycles.
// RULE_15: literal add, subtract, and, or, xor, load with matching flags.
// RULE_16: return with literal, plain return, interrupt return; two cycles.
// RULE_17: watchdog clear and sleep words update expired and sleep flags.
// RULE_18: port register read as source uses pin levels.
// RULE_19: write to timer zero count clears prescaler if assigned.
// RULE_20: zero on zero result; carries from bits 7 and 3; subtract inverts borrow.
// RULE_21: unlisted patterns execute as no-operation.
module instr_decoder
	import core_pkg::*;
#(
	parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01,
	parameter logic [6:0] PORT_LOW_ADDR = 7'h05,
	parameter logic [6:0] PORT_HIGH_ADDR = 7'h07
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire wb_req_t wb_req,
	output var wb_rsp_t wb_rsp,
	input wire logic [13:0] instr_word,
	output wire logic instr_fetch,
	output wire logic [6:0] file_addr,
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] pin_levels,
	output wire logic file_wr_en,
	output wire logic [7:0] file_wr_data,
	output var flow_ctl_t flow_ctl,
	input wire logic prescaler_assigned,
	input wire logic watchdog_timeout
);

	core_state_t s_q;
	core_state_t s_d;
	op_t op;
	logic [8:0] sum9;
	logic [4:0] low5;
	logic [7:0] src;
	logic [7:0] res;
	logic to_file;
	logic to_acc;
	logic set_z;
	logic set_cdc;
	logic skip;
	logic bit_val;
	logic bus_hit;

	function automatic op_t decode_op(input logic [13:0] w);
		op_t o;
		o = no_operation; // RULE_21
		case (w[13:12]) // RULE_01
			`CLASS_BYTE: begin
				case (w[11:8])
					`BOP_STORE: begin
						if (w[7]) begin
							o = store_acc_to_reg;
						end else if (w[7:0] == `CW_RETURN) begin
							o = return_op; // RULE_16
						end else if (w[7:0] == `CW_INT_RETURN) begin
							o = interrupt_return_op; // RULE_16
						end else if (w[7:0] == `CW_WDT_CLEAR) begin
							o = watchdog_clear_op; // RULE_17
						end else if (w[7:0] == `CW_SLEEP) begin
							o = sleep_op; // RULE_17
						end else if ((w[7:0] & `IDLE_LOW_MASK) == `LIT_ZERO) begin
							o = no_operation; // RULE_05
						end
					end
					`BOP_CLEAR: begin
						if (w[7]) begin
							o = clear_reg;
						end else if (w[7:0] == `CW_CLEAR_ACC) begin
							o = clear_acc; // RULE_05
						end
					end
					`BOP_SUB: o = sub_acc_from_reg;
					`BOP_DEC: o = decrement_reg;
					`BOP_OR: o = or_acc_with_reg;
					`BOP_AND: o = and_acc_with_reg;
					`BOP_XOR: o = xor_acc_with_reg;
					`BOP_ADD: o = add_acc_to_reg;
					`BOP_MOVE: o = move_reg;
					`BOP_COMP: o = complement_reg;
					`BOP_INC: o = increment_reg;
					`BOP_DECSZ: o = decrement_skip_zero;
					`BOP_RRC: o = rotate_right_carry;
					`BOP_RLC: o = rotate_left_carry;
					`BOP_SWAP: o = swap_nibbles;
					default: o = increment_skip_zero;
				endcase
			end
			`CLASS_BIT: begin
				case (w[11:10]) // RULE_12
					`BITOP_CLEAR: o = bit_clear_op;
					`BITOP_SET: o = bit_set_op;
					`BITOP_SKIP_CLR: o = test_skip_if_clear;
					default: o = test_skip_if_set;
				endcase
			end
			`CLASS_JUMP: begin
				o = w[11] ? jump_op : call_op; // RULE_14
			end
			default: begin
				casez (w[11:8]) // RULE_15
					`LOP_ADD: o = add_literal_op;
					`LOP_SUB: o = sub_from_literal_op;
					`LOP_AND: o = and_literal_op;
					`LOP_OR: o = or_literal_op;
					`LOP_XOR: o = xor_literal_op;
					`LOP_LOAD: o = load_literal_op;
					`LOP_RETURN: o = return_with_literal; // RULE_16
					default: o = no_operation; // RULE_21
				endcase
			end
		endcase
		return o;
	endfunction : decode_op

	function automatic logic is_port(input logic [6:0] a);
		return (a >= PORT_LOW_ADDR) && (a <= PORT_HIGH_ADDR);
	endfunction : is_port

	always_comb begin
		s_d = s_q;
		s_d.instr_fetch = 1'b0;
		s_d.file_wr_en = 1'b0;
		s_d.flow = '0;
		s_d.wb.ack = 1'b0;
		op = s_q.exec_nop ? no_operation : decode_op(s_q.ir); // RULE_13
		src = (s_q.ir[13:12] == `CLASS_LIT) ? s_q.ir[7:0] : s_q.operand;
		sum9 = 9'h000;
		low5 = 5'h00;
		res = src;
		to_file = 1'b0;
		to_acc = 1'b0;
		set_z = 1'b0;
		set_cdc = 1'b0;
		skip = 1'b0;
		bit_val = src[s_q.ir[9:7]]; // RULE_04
		bus_hit = wb_req.cyc && wb_req.stb && !s_q.wb.ack;

		// software-visible registers; hardware updates below take priority
		if (bus_hit) begin
			s_d.wb.ack = 1'b1;
			s_d.wb.dat = 32'h0000_0000;
			if (wb_req.adr == `REG_CTRL) begin
				s_d.wb.dat[`CTRL_RUN] = s_q.run;
				if (wb_req.we && wb_req.sel[0]) begin
					s_d.run = wb_req.dat[`CTRL_RUN];
				end
			end else if (wb_req.adr == `REG_ACC) begin
				s_d.wb.dat[7:0] = s_q.acc;
				if (wb_req.we && wb_req.sel[0]) begin
					s_d.acc = wb_req.dat[7:0];
				end
			end else if (wb_req.adr == `REG_STATUS) begin
				s_d.wb.dat[`ST_C] = s_q.carry;
				s_d.wb.dat[`ST_NIBBLE] = s_q.nibble_carry;
				s_d.wb.dat[`ST_Z] = s_q.zero;
				s_d.wb.dat[`ST_SLEPT] = s_q.sleep_entered_flag;
				s_d.wb.dat[`ST_EXPIRED] = s_q.watchdog_expired_flag;
				if (wb_req.we && wb_req.sel[0]) begin
					s_d.carry = wb_req.dat[`ST_C];
					s_d.nibble_carry = wb_req.dat[`ST_NIBBLE];
					s_d.zero = wb_req.dat[`ST_Z];
				end
			end else if (wb_req.adr == `REG_INFO) begin
				s_d.wb.dat = {s_q.cycle_count, 2'h0, s_q.ir};
			end
		end

		if (watchdog_timeout) begin
			s_d.watchdog_expired_flag = 1'b0;
		end

		// a started instruction always completes even if run drops
		case (s_q.phase) // RULE_07
			phase_q1: begin
				if (s_q.run) begin
					s_d.ir = instr_word;
					s_d.exec_nop = s_q.flush;
					s_d.flush = 1'b0;
					s_d.instr_fetch = 1'b1;
					s_d.file_addr = instr_word[6:0]; // RULE_02
					s_d.phase = phase_q2;
				end
			end
			phase_q2: begin
				// ports read back through the pins, not the output latch
				s_d.operand = is_port(s_q.file_addr) ? pin_levels : file_rd_data; // RULE_18
				s_d.phase = phase_q3;
			end
			phase_q3: begin
				s_d.phase = phase_q4;
			end
			phase_q4: begin
				s_d.phase = phase_q1;
				s_d.cycle_count = s_q.cycle_count + 16'h0001;
				case (op)
					add_acc_to_reg, add_literal_op: begin
						sum9 = {1'b0, src} + {1'b0, s_q.acc}; // RULE_08
						low5 = {1'b0, src[3:0]} + {1'b0, s_q.acc[3:0]};
						res = sum9[7:0];
						set_cdc = 1'b1;
						set_z = 1'b1;
					end
					sub_acc_from_reg, sub_from_literal_op: begin
						sum9 = {1'b0, src} + {1'b0, ~s_q.acc} + 9'h001; // RULE_20
						low5 = {1'b0, src[3:0]} + {1'b0, ~s_q.acc[3:0]} + 5'h01;
						res = sum9[7:0];
						set_cdc = 1'b1;
						set_z = 1'b1;
					end
					and_acc_with_reg, and_literal_op: begin
						res = src & s_q.acc;
						set_z = 1'b1;
					end
					or_acc_with_reg, or_literal_op: begin
						res = src | s_q.acc;
						set_z = 1'b1;
					end
					xor_acc_with_reg, xor_literal_op: begin
						res = src ^ s_q.acc;
						set_z = 1'b1;
					end
					decrement_reg, decrement_skip_zero: begin
						res = src - 8'h01; // RULE_09
						set_z = (op == decrement_reg);
						skip = (op == decrement_skip_zero) && (res == `LIT_ZERO);
					end
					increment_reg, increment_skip_zero: begin
						res = src + 8'h01; // RULE_09
						set_z = (op == increment_reg);
						skip = (op == increment_skip_zero) && (res == `LIT_ZERO);
					end
					rotate_left_carry: begin
						res = {src[6:0], s_q.carry}; // RULE_10
						s_d.carry = src[7];
					end
					rotate_right_carry: begin
						res = {s_q.carry, src[7:1]}; // RULE_10
						s_d.carry = src[0];
					end
					complement_reg: begin
						res = ~src; // RULE_11
						set_z = 1'b1;
					end
					move_reg: begin
						set_z = 1'b1; // RULE_11
					end
					swap_nibbles: begin
						res = {src[3:0], src[7:4]}; // RULE_11
					end
					clear_reg, clear_acc: begin
						res = `LIT_ZERO; // RULE_11
						set_z = 1'b1;
					end
					store_acc_to_reg: begin
						res = s_q.acc; // RULE_11
					end
					bit_clear_op: begin
						res[s_q.ir[9:7]] = 1'b0; // RULE_04
					end
					bit_set_op: begin
						res[s_q.ir[9:7]] = 1'b1; // RULE_04
					end
					test_skip_if_clear: begin
						skip = !bit_val; // RULE_13
					end
					test_skip_if_set: begin
						skip = bit_val; // RULE_13
					end
					load_literal_op: begin
						res = src; // RULE_15
					end
					call_op, jump_op: begin
						s_d.flow.pc_load = 1'b1; // RULE_14
						s_d.flow.pc_target = s_q.ir[10:0];
						s_d.flow.call_push = (op == call_op);
						skip = 1'b1;
					end
					return_with_literal, return_op, interrupt_return_op: begin
						s_d.flow.return_pop = 1'b1; // RULE_16
						s_d.flow.interrupt_return = (op == interrupt_return_op);
						skip = 1'b1;
					end
					watchdog_clear_op: begin
						s_d.flow.watchdog_clear = 1'b1; // RULE_17
						s_d.watchdog_expired_flag = 1'b1;
						s_d.sleep_entered_flag = 1'b1;
					end
					sleep_op: begin
						s_d.flow.watchdog_clear = 1'b1; // RULE_17
						s_d.flow.sleep_req = 1'b1;
						s_d.watchdog_expired_flag = 1'b1;
						s_d.sleep_entered_flag = 1'b0;
					end
					default: begin
						res = src; // RULE_21
					end
				endcase

				case (op)
					store_acc_to_reg, clear_reg, bit_clear_op, bit_set_op: begin
						to_file = 1'b1;
					end
					add_acc_to_reg, and_acc_with_reg, complement_reg, decrement_reg,
					decrement_skip_zero, increment_reg, increment_skip_zero,
					or_acc_with_reg, move_reg, rotate_left_carry, rotate_right_carry,
					sub_acc_from_reg, swap_nibbles, xor_acc_with_reg: begin
						to_file = s_q.ir[7]; // RULE_03
						to_acc = !s_q.ir[7]; // RULE_03
					end
					clear_acc, add_literal_op, and_literal_op, or_literal_op,
					xor_literal_op, sub_from_literal_op, load_literal_op,
					return_with_literal: begin
						to_acc = 1'b1;
					end
					default: begin
						to_acc = 1'b0;
					end
				endcase

				if (to_acc) begin
					s_d.acc = res;
				end
				if (to_file) begin
					s_d.file_wr_en = 1'b1;
					s_d.file_wr_data = res;
					// a count write restarts the prescaler chain too
					s_d.flow.prescaler_clear =
						(s_q.file_addr == TIMER_ZERO_ADDR) && prescaler_assigned; // RULE_19
				end
				if (set_z) begin
					s_d.zero = (res == `LIT_ZERO); // RULE_20
				end
				if (set_cdc) begin
					s_d.carry = sum9[8]; // RULE_20
					s_d.nibble_carry = low5[4]; // RULE_20
				end
				s_d.flush = skip; // RULE_06
			end
			default: begin
				s_d.phase = phase_q1;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.phase <= phase_q1;
			s_q.acc <= `ACC_RESET;
			s_q.watchdog_expired_flag <= 1'b1;
			s_q.sleep_entered_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_rsp = s_q.wb;
	assign instr_fetch = s_q.instr_fetch;
	assign file_addr = s_q.file_addr;
	assign file_wr_en = s_q.file_wr_en;
	assign file_wr_data = s_q.file_wr_data;
	assign flow_ctl = s_q.flow;

endmodule : instr_decoder
`default_nettype wire

// ### testbench/decoder_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module decoder_monitor
	import core_pkg::*;
#(
	parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire wb_req_t wb_req,
	input wire wb_rsp_t wb_rsp,
	input wire logic instr_fetch,
	input wire logic [6:0] file_addr,
	input wire logic file_wr_en,
	input wire flow_ctl_t flow_ctl,
	input wire logic prescaler_assigned
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic commit;
	// file writes, PC loads, sleep and watchdog clears of an executed word, so the no-op slot after a branch can be seen
	assign commit = file_wr_en | flow_ctl.pc_load | flow_ctl.sleep_req | flow_ctl.watchdog_clear;
	a_ack_single: assert property (wb_rsp.ack |=> !wb_rsp.ack)
		else $error("bus ack longer than one cycle");
	a_ack_answer: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
		else $error("bus request not answered next cycle");
	a_ack_cause: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.cyc && wb_req.stb))
		else $error("bus ack without request");
	a_fetch_gap: assert property (instr_fetch |=> !instr_fetch [*3])
		else $error("fetches closer than four clocks");
	a_commit_delay: assert property (commit |-> $past(instr_fetch, 3))
		else $error("result not three cycles after fetch");
	a_branch_bubble: assert property (flow_ctl.pc_load |=> !commit [*7])
		else $error("word after branch not a no-op");
	a_prescaler_clear: assert property (flow_ctl.prescaler_clear ==
		(file_wr_en && file_addr == TIMER_ZERO_ADDR && prescaler_assigned))
		else $error("prescaler clear mismatch");
	a_sleep_wdt: assert property (flow_ctl.sleep_req |-> flow_ctl.watchdog_clear)
		else $error("sleep without watchdog clear");
	c_bus_write: cover property (wb_rsp.ack && wb_req.we);
	c_jump: cover property (flow_ctl.pc_load);
	c_sleep: cover property (flow_ctl.sleep_req);
	c_prescaler: cover property (flow_ctl.prescaler_clear);
endmodule : decoder_monitor
bind instr_decoder decoder_monitor #(.TIMER_ZERO_ADDR(TIMER_ZERO_ADDR)) mon (
	.ref_clk(ref_clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
	.instr_fetch(instr_fetch), .file_addr(file_addr), .file_wr_en(file_wr_en),
	.flow_ctl(flow_ctl), .prescaler_assigned(prescaler_assigned)
);
`default_nettype wire

// ### testbench/program_memory.sv
`timescale 1ns/10ps
`default_nettype none
module program_memory (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic instr_fetch,
	input wire logic [6:0] file_addr,
	input wire logic file_wr_en,
	input wire logic [7:0] file_wr_data,
	output logic [13:0] instr_word,
	output logic [7:0] file_rd_data
);
	logic [13:0] rom [256] = '{default: 14'h0000};
	logic [7:0] regs [128] = '{default: 8'h00};
	logic [7:0] pc;
	// straight-line fetch only: branches are judged from the pulses, not followed
	assign instr_word = rom[pc];
	assign file_rd_data = regs[file_addr];
	always @(posedge ref_clk) begin
		if (reset) begin
			pc <= 8'h00;
		end else if (instr_fetch) begin
			pc <= pc + 8'h01;
		end
		if (file_wr_en) begin
			regs[file_addr] <= file_wr_data;
		end
	end
endmodule : program_memory
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import core_pkg::*;
	// words after call, return with literal, interrupt return and return would overwrite
	// registers that are checked at the end if they were not discarded
	localparam logic [13:0] PROG [27] = '{14'h303f, 14'h3e01, 14'h00a0, 14'h07a0, 14'h0e20,
		14'h15a1, 14'h1da1, 14'h30ff, 14'h3a08, 14'h2805, 14'h3055, 14'h0081, 14'h0070,
		14'h0060, 14'h0805, 14'h3ca5, 14'h0064, 14'h0063, 14'h2003, 14'h00a1, 14'h3442,
		14'h00a0, 14'h0d20, 14'h0009, 14'h01a1, 14'h0008, 14'h01a0};
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	wb_req_t wb_req = '0;
	wb_rsp_t wb_rsp;
	logic [13:0] instr_word;
	logic instr_fetch;
	logic [6:0] file_addr;
	logic [7:0] file_rd_data;
	logic [7:0] pin_levels = 8'ha5;
	logic file_wr_en;
	logic [7:0] file_wr_data;
	flow_ctl_t flow_ctl;
	logic prescaler_assigned = 1'b1;
	logic watchdog_timeout = 1'b0;
	int miscompares = 0;
	int num_checks = 0;
	int n_load = 0;
	int n_wdc = 0;
	int n_sleep = 0;
	int n_pre = 0;
	int n_call = 0;
	int n_ret = 0;
	int n_iret = 0;
	int n;
	logic [10:0] last_target = '0;
	logic [31:0] rd;

	instr_decoder uut (
		.ref_clk(ref_clk), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.instr_word(instr_word), .instr_fetch(instr_fetch), .file_addr(file_addr),
		.file_rd_data(file_rd_data), .pin_levels(pin_levels), .file_wr_en(file_wr_en),
		.file_wr_data(file_wr_data), .flow_ctl(flow_ctl),
		.prescaler_assigned(prescaler_assigned), .watchdog_timeout(watchdog_timeout)
	);
	program_memory pm (
		.ref_clk(ref_clk), .reset(reset), .instr_fetch(instr_fetch), .file_addr(file_addr),
		.file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .instr_word(instr_word),
		.file_rd_data(file_rd_data)
	);

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (flow_ctl.pc_load === 1'b1) begin
			n_load++;
			last_target = flow_ctl.pc_target;
		end
		if (flow_ctl.watchdog_clear === 1'b1) n_wdc++;
		if (flow_ctl.sleep_req === 1'b1) n_sleep++;
		if (flow_ctl.prescaler_clear === 1'b1) n_pre++;
		if (flow_ctl.call_push === 1'b1) n_call++;
		if (flow_ctl.return_pop === 1'b1) n_ret++;
		if (flow_ctl.interrupt_return === 1'b1) n_iret++;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// called just after a rising edge; leaves cyc low for one cycle before returning
	task automatic wb_access(logic we, logic [7:0] adr, logic [31:0] dat);
		int k;
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (wb_rsp.ack !== 1'b1 && k < 50);
		rd = wb_rsp.dat;
		check("wb_ack", 32'h1, {31'h0, wb_rsp.ack});
		wb_req <= '0;
		@(posedge ref_clk);
	endtask : wb_access

	task automatic rchk(string name, logic [7:0] adr, logic [31:0] exp);
		wb_access(1'b0, adr, 32'h0);
		check(name, exp, rd);
	endtask : rchk

	initial begin
		#(50 * 5000);
		miscompares++;
		report_and_stop();
	end

	initial begin
		foreach (PROG[i]) pm.rom[i] = PROG[i];
		pm.regs[1] = 8'h77;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		rchk("status_rst", 8'h08, 32'h18);
		rchk("acc_rst", 8'h04, 32'h0);
		rchk("unmapped", 8'h10, 32'h0);
		wb_access(1'b1, 8'h10, 32'h5a);
		wb_access(1'b1, 8'h04, 32'h3c);
		rchk("acc_rw", 8'h04, 32'h3c);
		watchdog_timeout <= 1'b1;
		@(posedge ref_clk);
		watchdog_timeout <= 1'b0;
		wb_access(1'b1, 8'h08, 32'h1f);
		rchk("status_ro", 8'h08, 32'h0f);
		wb_access(1'b1, 8'h00, 32'h1);
		n = 0;
		while (pm.pc < 8'd30 && n < 500) begin
			@(posedge ref_clk);
			n++;
		end
		wb_access(1'b1, 8'h00, 32'h0);
		rchk("acc_end", 8'h04, 32'h01);
		rchk("status_end", 8'h08, 32'h17);
		check("reg_20", 32'h80, pm.regs[7'h20]);
		check("reg_21", 32'h08, pm.regs[7'h21]);
		check("reg_01", 32'h00, pm.regs[7'h01]);
		check("pc_loads", 32'd2, n_load);
		check("pc_target", 32'h003, last_target);
		check("calls", 32'd1, n_call);
		check("returns", 32'd3, n_ret);
		check("int_returns", 32'd1, n_iret);
		check("prescaler", 32'd1, n_pre);
		check("wdt_clears", 32'd2, n_wdc);
		check("sleeps", 32'd1, n_sleep);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
